// ==== logic/usb_ep_pkg.sv ====
package usb_ep_pkg;
  localparam logic [7:0] ADDR_REG = 8'h10;
  localparam logic [7:0] CTRL_CNT_REG = 8'h11;
  localparam logic [7:0] CTRL_MODE_REG = 8'h12;
  localparam logic [7:0] EP1_CNT_REG = 8'h13;
  localparam logic [7:0] FIRST_DATA_EP_MODE_REG = 8'h14;
  localparam logic [7:0] EP2_CNT_REG = 8'h15;
  localparam logic [7:0] SECOND_DATA_EP_MODE_REG = 8'h16;
  localparam logic [7:0] STATUS_CTRL_REG = 8'h1F;
  localparam logic [7:0] CTRL_BUF_BASE = 8'hF8;
  localparam logic [7:0] EP1_BUF_BASE = 8'hF0;
  localparam logic [7:0] EP2_BUF_BASE = 8'hE8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] MODE_NAK_BOTH = 4'h1;
  localparam logic [3:0] MODE_ACK_OUT_NAK_IN = 4'hB;
  localparam logic [3:0] MODE_ACK_OUT = 4'h9;
  localparam logic [3:0] MODE_ACK_IN = 4'hD;
  localparam logic [2:0] FORCE_NONE = 3'h0;
  localparam logic [2:0] FORCE_RELEASE = 3'h7;
  localparam logic [3:0] CRC_BYTES = 4'h2;
  localparam logic [3:0] MAX_IN_BYTES = 4'h8;
  localparam int CLK_MHZ = 10;
  localparam int SE0_MIN_US = 128;
  localparam int SE0_CYCLES = SE0_MIN_US * CLK_MHZ;
  localparam int SE0_CW = 12;

  typedef enum logic [1:0] {
    TOK_SETUP = 2'b00,
    TOK_IN = 2'b01,
    TOK_OUT = 2'b10
  } token_t;

  typedef enum logic [1:0] {
    HS_NONE = 2'b00,
    HS_ACK = 2'b01,
    HS_NAK = 2'b10,
    HS_STALL = 2'b11
  } handshake_t;

  // Token from serial engine
  typedef struct packed {
    logic valid;
    token_t kind;
    logic [6:0] addr;
    logic [1:0] ep;
  } token_req_t;

  // Received data packet result
  typedef struct packed {
    logic valid;
    logic toggle;
    logic error;
    logic [3:0] nbytes;
  } rx_done_t;
endpackage

// ==== logic/usb_ep_regs.sv ====
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module usb_ep_regs
  import usb_ep_pkg::*;
#(
  parameter int SE0_CNT = SE0_CYCLES
)
(
  input wire logic clock_in, // 10 MHz clock
  input wire logic nrst_in, // Async reset, low
  input wire logic [7:0] addr_in, // Register address
  input wire logic [7:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [7:0] rdata_out, // Read data, next cycle
  input wire token_req_t token_in, // Decoded token pulse
  input wire logic setup_data_start_in, // Setup data packet begins
  input wire logic handshake_start_in, // Handshake begins
  input wire rx_done_t rx_in, // Data packet done pulse
  input wire logic [7:0] rx_byte_in, // Received byte
  input wire logic rx_byte_valid_in, // Received byte strobe
  input wire logic tx_byte_req_in, // Engine wants next IN byte
  input wire logic host_ack_in, // Host ACKed our IN data
  input wire logic dp_in, // D+ line level
  input wire logic dm_in, // D- line level
  output logic [1:0] handshake_out, // Handshake to send
  output logic hs_valid_out, // Handshake pulse
  output logic [7:0] tx_byte_out, // IN byte
  output logic tx_toggle_out, // IN toggle
  output logic [3:0] tx_count_out, // IN byte count
  output logic tx_last_out, // Last IN data byte, then CRC
  output logic ep_event_out, // Endpoint event pulse
  output logic bus_reset_out, // Bus reset pulse
  output logic [2:0] force_out // Line forcing code
);
  logic [7:0] device_address;
  logic [7:0] count_r [3];
  logic [7:0] mode_r [3];
  logic [7:0] status_ctrl;
  logic [7:0] mem [24];
  logic count_lock;
  logic setup_hold;
  logic [1:0] cur_ep;
  token_t cur_tok;
  logic cur_active;
  logic [2:0] wr_ptr;
  logic [2:0] rd_ptr;
  logic [3:0] tx_sent;
  logic [SE0_CW-1:0] se0_cnt;
  logic bus_reset;
  logic [1:0] reg_ep;
  logic is_cnt;
  logic is_mode;
  logic hit;
  handshake_t hs;
  logic [3:0] m;
  logic [4:0] buf_idx;
  logic buf_hit;

  // Register decode to endpoint index
  always_comb
  begin
    reg_ep = 2'd0;
    is_cnt = 1'b0;
    is_mode = 1'b0;
    if (addr_in == CTRL_CNT_REG)
    begin
      is_cnt = 1'b1;
    end
    else if (addr_in == CTRL_MODE_REG)
    begin
      is_mode = 1'b1;
    end
    else if (addr_in == EP1_CNT_REG)
    begin
      is_cnt = 1'b1;
      reg_ep = 2'd1;
    end
    else if (addr_in == FIRST_DATA_EP_MODE_REG)
    begin
      is_mode = 1'b1;
      reg_ep = 2'd1;
    end
    else if (addr_in == EP2_CNT_REG)
    begin
      is_cnt = 1'b1;
      reg_ep = 2'd2;
    end
    else if (addr_in == SECOND_DATA_EP_MODE_REG)
    begin
      is_mode = 1'b1;
      reg_ep = 2'd2;
    end
  end

  // Buffer window decode, index 0..23 from 0xE8
  always_comb
  begin
    buf_hit = (addr_in >= EP2_BUF_BASE);
    buf_idx = 5'(addr_in - EP2_BUF_BASE);
  end

  // Address match and handshake choice
  always_comb
  begin
    hit = token_in.valid && device_address[7] && (token_in.addr == device_address[6:0])
      && (token_in.ep != 2'd3);
    m = mode_r[token_in.ep][3:0];
    hs = HS_NAK;
    if (token_in.kind == TOK_SETUP)
    begin
      hs = (token_in.ep == 2'd0) ? HS_ACK : HS_NAK;
    end
    else if (m == MODE_NAK_BOTH)
    begin
      hs = HS_NAK;
    end
    else if (token_in.kind == TOK_OUT && (m == MODE_ACK_OUT || m == MODE_ACK_OUT_NAK_IN))
    begin
      hs = (token_in.ep != 2'd0 && mode_r[token_in.ep][7]) ? HS_STALL : HS_ACK;
    end
    else if (token_in.kind == TOK_IN && m == MODE_ACK_IN)
    begin
      hs = (token_in.ep != 2'd0 && mode_r[token_in.ep][7]) ? HS_STALL : HS_ACK;
    end
  end

  // Bus reset: both lines low long enough in USB mode
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      se0_cnt <= '0;
      bus_reset <= 1'b0;
    end
    else
    begin
      bus_reset <= 1'b0;
      if (!dp_in && !dm_in && !status_ctrl[5])
      begin
        if (se0_cnt == SE0_CW'(SE0_CNT - 1))
        begin
          bus_reset <= 1'b1;
        end
        if (se0_cnt != SE0_CW'(SE0_CNT))
        begin
          se0_cnt <= se0_cnt + 1'b1;
        end
      end
      else
      begin
        se0_cnt <= '0;
      end
    end
  end

  // Device address register
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      device_address <= REG_RESET;
    end
    else if (bus_reset)
    begin
      device_address <= REG_RESET;
    end
    else if (wr_in && addr_in == ADDR_REG)
    begin
      device_address <= wdata_in;
    end
  end

  // Status and control register holding the forcing code
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      status_ctrl <= REG_RESET;
    end
    else if (wr_in && addr_in == STATUS_CTRL_REG)
    begin
      status_ctrl <= {wdata_in[7:5], 1'b0, wdata_in[3:0]};
    end
  end

  // Transaction tracking
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cur_active <= 1'b0;
      cur_ep <= 2'd0;
      cur_tok <= TOK_SETUP;
      handshake_out <= HS_NONE;
      hs_valid_out <= 1'b0;
      setup_hold <= 1'b0;
    end
    else
    begin
      hs_valid_out <= 1'b0;
      if (hit)
      begin
        cur_active <= 1'b1;
        cur_ep <= token_in.ep;
        cur_tok <= token_in.kind;
        handshake_out <= hs;
        hs_valid_out <= (token_in.kind == TOK_IN); // IN answers at once with data or handshake
      end
      else if (rx_in.valid && cur_active)
      begin
        hs_valid_out <= !rx_in.error;
      end
      if (setup_data_start_in && cur_active && cur_tok == TOK_SETUP)
      begin
        setup_hold <= 1'b1;
      end
      else if (handshake_start_in)
      begin
        setup_hold <= 1'b0;
        cur_active <= 1'b0;
      end
    end
  end

  // Mode registers for all three endpoints in one block
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (int i = 0; i < 3; i++)
      begin
        mode_r[i] <= REG_RESET;
      end
    end
    else
    begin
      if (wr_in && is_mode)
      begin
        if (reg_ep == 2'd0)
        begin
          if (!count_lock)
          begin
            mode_r[0] <= {4'h0, wdata_in[3:0]};
          end
        end
        else
        begin
          mode_r[reg_ep] <= {wdata_in[7], 2'b00, mode_r[reg_ep][4] & ~wdata_in[4], wdata_in[3:0]};
        end
      end
      if (setup_hold)
      begin
        mode_r[0][7] <= 1'b1;
      end
      if (cur_active && rx_in.valid && cur_tok != TOK_IN)
      begin
        if (cur_tok == TOK_OUT && cur_ep == 2'd0)
        begin
          mode_r[0][5] <= 1'b1;
        end
        if (!rx_in.error && handshake_out == HS_ACK)
        begin
          mode_r[cur_ep][4] <= 1'b1;
          if (cur_tok == TOK_OUT && mode_r[cur_ep][3:0] == MODE_ACK_OUT_NAK_IN)
          begin
            mode_r[cur_ep][3:0] <= MODE_NAK_BOTH;
          end
        end
      end
      if (cur_active && cur_tok == TOK_IN && host_ack_in)
      begin
        mode_r[cur_ep][4] <= 1'b1;
        if (cur_ep == 2'd0)
        begin
          mode_r[0][6] <= 1'b1;
        end
      end
    end
  end

  // Count registers and control count lock
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (int i = 0; i < 3; i++)
      begin
        count_r[i] <= REG_RESET;
      end
      count_lock <= 1'b0;
    end
    else
    begin
      if (rd_in && addr_in == CTRL_CNT_REG)
      begin
        count_lock <= 1'b0;
      end
      if (wr_in && is_cnt && !(reg_ep == 2'd0 && count_lock))
      begin
        count_r[reg_ep] <= {wdata_in[7:6], 2'b00, wdata_in[3:0]};
      end
      if (cur_active && rx_in.valid && cur_tok != TOK_IN)
      begin
        count_r[cur_ep] <= {rx_in.toggle, !rx_in.error, 2'b00, rx_in.nbytes + CRC_BYTES};
        if (cur_ep == 2'd0)
        begin
          count_lock <= 1'b1;
        end
      end
    end
  end

  // Endpoint buffers: receive fill, processor access, IN send
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (int i = 0; i < 24; i++)
      begin
        mem[i] <= REG_RESET;
      end
    end
    else
    begin
      if (wr_in && buf_hit && !(buf_idx >= 5'd16 && mode_r[0][7]))
      begin
        mem[buf_idx] <= wdata_in;
      end
      if (rx_byte_valid_in && cur_active)
      begin
        mem[{2'd2 - cur_ep, 3'b000} + 5'(wr_ptr)] <= rx_byte_in;
      end
    end
  end

  // Buffer pointers for the current transaction
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_ptr <= 3'd0;
      rd_ptr <= 3'd0;
      tx_sent <= 4'd0;
      tx_byte_out <= REG_RESET;
      tx_last_out <= 1'b0;
      tx_toggle_out <= 1'b0;
      tx_count_out <= 4'd0;
    end
    else
    begin
      tx_last_out <= 1'b0;
      if (hit)
      begin
        wr_ptr <= 3'd0;
        rd_ptr <= 3'd0;
        tx_sent <= 4'd0;
        tx_toggle_out <= count_r[token_in.ep][7];
        tx_count_out <= (count_r[token_in.ep][3:0] > MAX_IN_BYTES) ? MAX_IN_BYTES : count_r[token_in.ep][3:0];
      end
      else
      begin
        if (rx_byte_valid_in && cur_active)
        begin
          wr_ptr <= wr_ptr + 3'd1;
        end
        if (tx_byte_req_in && cur_active && cur_tok == TOK_IN && tx_sent < tx_count_out)
        begin
          tx_byte_out <= mem[{2'd2 - cur_ep, 3'b000} + 5'(rd_ptr)];
          rd_ptr <= rd_ptr + 3'd1;
          tx_sent <= tx_sent + 4'd1;
          tx_last_out <= (tx_sent + 4'd1 == tx_count_out);
        end
      end
    end
  end

  // Event and line outputs
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ep_event_out <= 1'b0;
      bus_reset_out <= 1'b0;
      force_out <= FORCE_NONE;
    end
    else
    begin
      ep_event_out <= (cur_active && rx_in.valid) || (cur_active && cur_tok == TOK_IN && host_ack_in);
      bus_reset_out <= bus_reset;
      // New forcing code reaches the pins in the same cycle as the register
      force_out <= (wr_in && addr_in == STATUS_CTRL_REG) ? wdata_in[2:0] : status_ctrl[2:0];
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_out <= REG_RESET;
    end
    else if (rd_in)
    begin
      if (addr_in == ADDR_REG)
      begin
        rdata_out <= device_address;
      end
      else if (is_cnt)
      begin
        rdata_out <= count_r[reg_ep];
      end
      else if (is_mode)
      begin
        rdata_out <= mode_r[reg_ep];
      end
      else if (addr_in == STATUS_CTRL_REG)
      begin
        rdata_out <= status_ctrl;
      end
      else if (buf_hit)
      begin
        rdata_out <= mem[buf_idx];
      end
      else
      begin
        rdata_out <= REG_RESET;
      end
    end
    else
    begin
      rdata_out <= REG_RESET;
    end
  end
endmodule

// ==== verif/test_usb_endpoint_control_regs.sv ====
`timescale 1ns/1ns
module test_usb_endpoint_control_regs;
  import usb_ep_pkg::*;
  localparam logic [6:0] DEV = 7'h05;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out, tx_byte_out, rxb;
  logic [1:0] handshake_out;
  logic [3:0] tx_count_out;
  logic [2:0] force_out, strb;
  logic hs_valid_out, tx_toggle_out, tx_last_out, ep_event_out, bus_reset_out, ss, rxv, dp, dm, seen;
  token_req_t tok;
  rx_done_t rx;
  logic [7:0] d [8];
  logic [31:0] seed = 32'd60;
  int err_count = 0;
  int checks_done = 0;
  int i;
  always #50 clock_in = ~clock_in;
  usb_ep_regs #(.SE0_CNT(20)) u_dut (
    .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .token_in(tok), .setup_data_start_in(ss),
    .handshake_start_in(strb[0]), .rx_in(rx), .rx_byte_in(rxb), .rx_byte_valid_in(rxv),
    .tx_byte_req_in(strb[1]), .host_ack_in(strb[2]), .dp_in(dp), .dm_in(dm),
    .handshake_out(handshake_out), .hs_valid_out(hs_valid_out), .tx_byte_out(tx_byte_out),
    .tx_toggle_out(tx_toggle_out), .tx_count_out(tx_count_out), .tx_last_out(tx_last_out),
    .ep_event_out(ep_event_out), .bus_reset_out(bus_reset_out), .force_out(force_out));
  usb_host_model u_host (
    .clock_in(clock_in), .tok_out(tok), .setup_start_out(ss), .strb_out(strb), .rx_out(rx),
    .rx_byte_out(rxb), .rx_byte_valid_out(rxv), .dp_out(dp), .dm_out(dm));
  // Random source and expected count
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] cnt_exp(input logic tg, input logic v, input logic [3:0] n);
    return {tg, v, 2'b00, n + CRC_BYTES};
  endfunction
  // Compare, bus cycles, token with answer
  task automatic chk(input logic [7:0] seen_v, input logic [7:0] exp);
    checks_done++;
    if (seen_v !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen_v, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out & m, exp);
  endtask
  task automatic tokc(input token_t k, input logic [6:0] a, input logic [1:0] e, input logic [1:0] hs);
    u_host.send_token(k, a, e);
    chk({6'h00, handshake_out}, {6'h00, hs});
  endtask
  // Held SE0 with a bounded watch for the bus reset pulse
  task automatic se0c(input int n, input logic exp);
    int j;
    seen = 1'b0;
    fork
      u_host.se0(n);
      for (j = 0; j < 40 && !seen; j++)
      begin
        @(posedge clock_in);
        #1 seen = bus_reset_out;
      end
    join
    chk({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic test_done;
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    for (i = 0; i < 7; i++)
      rdc(ADDR_REG + 8'(i), 8'hFF, REG_RESET);
    wr(STATUS_CTRL_REG, {5'h00, FORCE_RELEASE});
    #1 chk({5'h00, force_out}, {5'h00, FORCE_RELEASE});
    wr(STATUS_CTRL_REG, {5'h00, FORCE_NONE});
    #1 chk({5'h00, force_out}, {5'h00, FORCE_NONE});
    for (i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      d[i] = seed[7:0];
      wr(ADDR_REG, {1'b0, seed[14:8]});
      rdc(ADDR_REG, 8'hFF, {1'b0, seed[14:8]});
    end
    tokc(TOK_OUT, seed[14:8], 2'd1, HS_NONE);
    wr(ADDR_REG, {1'b1, DEV});
    tokc(TOK_OUT, DEV + 7'h01, 2'd1, HS_NONE);
    wr(CTRL_MODE_REG, {4'h0, MODE_NAK_BOTH});
    tokc(TOK_IN, DEV, 2'd0, HS_NAK);
    tokc(TOK_OUT, DEV, 2'd0, HS_NAK);
    tokc(TOK_SETUP, DEV, 2'd0, HS_ACK);
    u_host.send_data(d, 8, 1'b0, 1'b0, 1'b1);
    wr(CTRL_MODE_REG, 8'h00);
    rdc(CTRL_MODE_REG, 8'h80, 8'h80);
    wr(CTRL_BUF_BASE, ~d[0]);
    for (i = 0; i < 8; i++)
      rdc(CTRL_BUF_BASE + 8'(i), 8'hFF, d[i]);
    wr(CTRL_CNT_REG, 8'h03);
    rdc(CTRL_CNT_REG, 8'hCF, cnt_exp(1'b0, 1'b1, 4'h8));
    wr(CTRL_CNT_REG, 8'h03);
    rdc(CTRL_CNT_REG, 8'h8F, 8'h03);
    u_host.strobe(3'h1);
    wr(CTRL_MODE_REG, 8'hF1);
    rdc(CTRL_MODE_REG, 8'hFF, 8'h01);
    wr(FIRST_DATA_EP_MODE_REG, {4'h0, MODE_ACK_OUT_NAK_IN});
    tokc(TOK_OUT, DEV, 2'd1, HS_ACK);
    u_host.send_data(d, 3, 1'b1, 1'b0, 1'b0);
    u_host.strobe(3'h1);
    rdc(FIRST_DATA_EP_MODE_REG, 8'h1F, 8'h11);
    rdc(EP1_CNT_REG, 8'hCF, cnt_exp(1'b1, 1'b1, 4'h3));
    for (i = 0; i < 3; i++)
      rdc(EP1_BUF_BASE + 8'(i), 8'hFF, d[i]);
    wr(SECOND_DATA_EP_MODE_REG, {4'h0, MODE_ACK_OUT});
    u_host.send_token(TOK_OUT, DEV, 2'd2);
    u_host.send_data(d, 5, 1'b0, 1'b1, 1'b0);
    rdc(EP2_CNT_REG, 8'h40, 8'h00);
    wr(FIRST_DATA_EP_MODE_REG, {4'h8, MODE_ACK_OUT});
    tokc(TOK_OUT, DEV, 2'd1, HS_STALL);
    wr(FIRST_DATA_EP_MODE_REG, {4'h8, MODE_ACK_IN});
    tokc(TOK_IN, DEV, 2'd1, HS_STALL);
    wr(FIRST_DATA_EP_MODE_REG, {4'h0, MODE_NAK_BOTH});
    rdc(FIRST_DATA_EP_MODE_REG, 8'h8F, {4'h0, MODE_NAK_BOTH});
    wr(SECOND_DATA_EP_MODE_REG, {4'h0, MODE_ACK_IN});
    for (i = 0; i < 3; i++)
      wr(EP2_BUF_BASE + 8'(i), d[i + 4]);
    wr(EP2_CNT_REG, 8'h83);
    u_host.send_token(TOK_IN, DEV, 2'd2);
    chk({3'h0, tx_toggle_out, tx_count_out}, 8'h13);
    for (i = 0; i < 3; i++)
    begin
      u_host.strobe(3'h2);
      chk(tx_byte_out, d[i + 4]);
    end
    chk({7'h00, tx_last_out}, 8'h01);
    u_host.strobe(3'h4);
    rdc(SECOND_DATA_EP_MODE_REG, 8'h1F, {4'h1, MODE_ACK_IN});
    wr(CTRL_MODE_REG, {4'h0, MODE_ACK_IN});
    tokc(TOK_IN, DEV, 2'd0, HS_ACK);
    u_host.strobe(3'h4);
    rdc(CTRL_MODE_REG, 8'hF0, 8'h50);
    wr(STATUS_CTRL_REG, 8'h20);
    se0c(25, 1'b0);
    wr(STATUS_CTRL_REG, 8'h00);
    se0c(25, 1'b1);
    rdc(ADDR_REG, 8'hFF, 8'h00);
    test_done;
  end
endmodule

// ==== verif/usb_ep_regs_properties.sv ====
`timescale 1ns/1ns
module usb_ep_regs_properties
  import usb_ep_pkg::*;
#(
  parameter int SE0_CNT = SE0_CYCLES
)
(
  input wire logic clock_in, // Clock
  input wire logic nrst_in, // Reset, low
  input wire logic [7:0] addr_in, // Address
  input wire logic [7:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  input wire logic [7:0] rdata_out, // Read data
  input wire token_req_t token_in, // Token
  input wire rx_done_t rx_in, // Packet done
  input wire logic dp_in, // D+ level
  input wire logic dm_in, // D- level
  input wire logic [1:0] handshake_out, // Handshake
  input wire logic hs_valid_out, // Handshake pulse
  input wire logic ep_event_out, // Endpoint event
  input wire logic bus_reset_out, // Bus reset
  input wire logic [2:0] force_out // Forcing code
);
  logic [7:0] last_wd;
  logic [7:0] addr_sh;
  logic [15:0] se0_run;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  // Last written byte, shadow address, SE0 length
  always_ff @(posedge clock_in or negedge nrst_in)
    if (!nrst_in) last_wd <= 8'h00;
    else if (wr_in) last_wd <= wdata_in;
  always_ff @(posedge clock_in or negedge nrst_in)
    if (!nrst_in) addr_sh <= 8'h00;
    else if (bus_reset_out) addr_sh <= 8'h00;
    else if (wr_in && addr_in == ADDR_REG) addr_sh <= wdata_in;
  always_ff @(posedge clock_in or negedge nrst_in)
    if (!nrst_in) se0_run <= 16'h0000;
    else if (dp_in || dm_in) se0_run <= 16'h0000;
    else se0_run <= se0_run + 16'h0001;
  // Mode write then read of first data endpoint
  sequence s_ep1_wr;
    wr_in && addr_in == FIRST_DATA_EP_MODE_REG;
  endsequence
  sequence s_ep1_rd;
    rd_in && addr_in == FIRST_DATA_EP_MODE_REG;
  endsequence
  property p_addr_rd;
    rd_in && addr_in == ADDR_REG |=> rdata_out == addr_sh;
  endproperty
  property p_first_data_ep_mode;
    s_ep1_wr ##2 s_ep1_rd |=> rdata_out[3:0] == last_wd[3:0];
  endproperty
  property p_force;
    wr_in && addr_in == STATUS_CTRL_REG |=> force_out == last_wd[2:0];
  endproperty
  property p_ignore;
    token_in.valid && (!addr_sh[7] || token_in.addr != addr_sh[6:0]) |=> !hs_valid_out && $stable(handshake_out);
  endproperty
  property p_err_event;
    rx_in.valid && rx_in.error |=> ep_event_out;
  endproperty
  property p_err_nohs;
    rx_in.valid && rx_in.error |=> !hs_valid_out;
  endproperty
  property p_hs_pulse;
    hs_valid_out |=> !hs_valid_out;
  endproperty
  property p_se0;
    bus_reset_out |-> se0_run >= SE0_CNT - 2;
  endproperty
  a_addr_rd: assert property (p_addr_rd)
    else $error("address readback differs from last write");
  a_first_data_ep_mode: assert property (p_first_data_ep_mode)
    else $error("data endpoint mode write lost");
  a_force: assert property (p_force)
    else $error("forcing code not taken");
  a_ignore: assert property (p_ignore)
    else $error("answer to foreign or disabled address");
  a_err_event: assert property (p_err_event)
    else $error("no event for bad packet");
  a_err_nohs: assert property (p_err_nohs)
    else $error("handshake after bad packet");
  a_hs_pulse: assert property (p_hs_pulse)
    else $error("handshake pulse too long");
  a_se0: assert property (p_se0)
    else $error("bus reset on short SE0");
endmodule

bind usb_ep_regs usb_ep_regs_properties #(.SE0_CNT(SE0_CNT)) u_props (
  .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .token_in(token_in), .rx_in(rx_in),
  .dp_in(dp_in), .dm_in(dm_in), .handshake_out(handshake_out), .hs_valid_out(hs_valid_out),
  .ep_event_out(ep_event_out), .bus_reset_out(bus_reset_out), .force_out(force_out)
);

// ==== verif/usb_host_model.sv ====
`timescale 1ns/1ns
module usb_host_model
  import usb_ep_pkg::*;
(
  input wire logic clock_in, // Clock
  output token_req_t tok_out, // Token pulse
  output logic setup_start_out, // Setup data begins
  output logic [2:0] strb_out, // Host ack, byte request, handshake start
  output rx_done_t rx_out, // Packet done
  output logic [7:0] rx_byte_out, // Data byte
  output logic rx_byte_valid_out, // Byte strobe
  output logic dp_out, // D+
  output logic dm_out // D-
);
  // Idle J state, no traffic
  initial
  begin
    tok_out = '0;
    setup_start_out = 1'b0;
    strb_out = 3'h0;
    rx_out = '0;
    rx_byte_out = 8'h00;
    rx_byte_valid_out = 1'b0;
    dp_out = 1'b0;
    dm_out = 1'b1;
  end
  // One token pulse
  task automatic send_token(input token_t k, input logic [6:0] a, input logic [1:0] e);
    @(posedge clock_in);
    tok_out <= '{1'b1, k, a, e};
    dp_out <= 1'b1; // K state while the token is on the line
    dm_out <= 1'b0;
    @(posedge clock_in);
    tok_out <= '0;
    dp_out <= 1'b0;
    dm_out <= 1'b1;
    #1;
  endtask
  // Data stage; byte bus shows junk after the last byte
  task automatic send_data(input logic [7:0] d [8], input int n, input logic tg, input logic er, input logic st);
    int i;
    @(posedge clock_in);
    setup_start_out <= st;
    for (i = 0; i < n; i++)
    begin
      @(posedge clock_in);
      setup_start_out <= 1'b0;
      rx_byte_out <= d[i];
      rx_byte_valid_out <= 1'b1;
    end
    @(posedge clock_in);
    rx_byte_valid_out <= 1'b0;
    rx_byte_out <= ~rx_byte_out;
    rx_out <= '{1'b1, tg, er, 4'(n)};
    @(posedge clock_in);
    rx_out <= '0;
    #1;
  endtask
  // One-cycle strobe
  task automatic strobe(input logic [2:0] w);
    @(posedge clock_in);
    strb_out <= w;
    @(posedge clock_in);
    strb_out <= 3'h0;
    #1;
  endtask
  // Held single-ended zero
  task automatic se0(input int n);
    @(posedge clock_in);
    dm_out <= 1'b0;
    repeat (n) @(posedge clock_in);
    dm_out <= 1'b1;
  endtask
endmodule
